// *** rtl/ipl_defs.svh ***
// register offsets, field positions and reset values of the level registers
`ifndef IPL_DEFS_SVH
`define IPL_DEFS_SVH

`define IPL_ADDR_W           4
`define IPL_DATA_W           16
`define IPL_OFS_TIMER_I2C    4'h4
`define IPL_OFS_PIT_CMP      4'h5
`define IPL_OFS_PWM_ADC      4'h6
`define IPL_RESET_VAL        16'h0000
// writable bits per register; reserved bits hold zero
`define IPL_MASK_TIMER_I2C   16'hFFFF
`define IPL_MASK_PIT_CMP     16'hFF00
`define IPL_MASK_PWM_ADC     16'h0FFF
`define IPL_FIELD_W          2
`define IPL_CODE_OFF         2'h0
`define IPL_FIELDS_PER_REG   8

`endif

// *** rtl/ipl_pkg.sv ***
// types shared by the priority level register block
package ipl_pkg;

    typedef logic [1:0] ipl_level_t;

    // decoded view of one source as seen by the arbiter
    typedef struct packed {
        logic       enable;
        ipl_level_t level;
    } ipl_src_t;

    // register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } ipl_bus_req_t;

endpackage : ipl_pkg

// *** rtl/ipl_level_regs.sv ***
// priority level registers for timer, i2c, interval timer, comparator, pwm and adc sources
//
// Decided for this implementation: the address-and-strobe port.
`include "ipl_defs.svh"

// Summary of operation
// - field code 00 disables, 01 level 0, 10 level 1, 11 level 2
// - no governed source ever gets a level above two
// - reset clears all fields so every source starts disabled
// - reserved bits ignore writes and read back as zero
// - offset 4 bits 15:14 are timer channel 3 level
// - offset 4 bits 13:12 are timer channel 2 level
// - offset 4 bits 11:10 are timer channel 1 level
// - offset 4 bits 9:8 are timer channel 0 level
// - offset 4 bits 7:6 are i2c status level
// - offset 4 bits 5:4 are i2c transmit level
// - offset 4 bits 3:2 are i2c receive level
// - offset 4 bits 1:0 are i2c general call level
// - offset 5 bits 15:14 are interval timer 1 level
// - offset 5 bits 13:12 are interval timer 0 level
// - offset 5 bits 11:10 are comparator B level
// - offset 5 bits 9:8 are comparator A level
// - offset 6 bits 11:10 are pwm fault level
// - offset 6 bits 9:8 are pwm reload level
// - offset 6 bits 7:6 are adc zero crossing level
// - offset 6 bits 5:4 are adc B conversion complete level
// - offset 6 bits 3:2 are adc A conversion complete level
// - offset 6 bits 1:0 are interval timer 2 level
module ipl_level_regs (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // register port
    input  wire ipl_pkg::ipl_bus_req_t busReq,
    output logic [15:0]        rdData,
    // decoded sources to arbitration
    output ipl_pkg::ipl_src_t  timerCh3Level,
    output ipl_pkg::ipl_src_t  timerCh2Level,
    output ipl_pkg::ipl_src_t  timerCh1Level,
    output ipl_pkg::ipl_src_t  timerCh0Level,
    output ipl_pkg::ipl_src_t  i2cStatusLevel,
    output ipl_pkg::ipl_src_t  i2cTransmitLevel,
    output ipl_pkg::ipl_src_t  i2cReceiveLevel,
    output ipl_pkg::ipl_src_t  i2cGeneralCallLevel,
    output ipl_pkg::ipl_src_t  intervalTimer1Level,
    output ipl_pkg::ipl_src_t  intervalTimer0Level,
    output ipl_pkg::ipl_src_t  comparatorBLevel,
    output ipl_pkg::ipl_src_t  comparatorALevel,
    output ipl_pkg::ipl_src_t  pwmFaultLevel,
    output ipl_pkg::ipl_src_t  pwmReloadLevel,
    output ipl_pkg::ipl_src_t  adcZeroCrossLevel,
    output ipl_pkg::ipl_src_t  adcBDoneLevel,
    output ipl_pkg::ipl_src_t  adcADoneLevel,
    output ipl_pkg::ipl_src_t  intervalTimer2Level
);
    import ipl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // field decode

    // code minus one gives the level, so 11 tops out at two
    function automatic ipl_src_t decodeField(input logic [1:0] code);
        ipl_src_t s;
        s.enable = (code != `IPL_CODE_OFF);
        s.level  = s.enable ? ipl_level_t'(code - 2'h1) : ipl_level_t'(2'h0);
        return s;
    endfunction : decodeField

    function automatic logic [1:0] fieldOf(input logic [15:0] r, input int idx);
        return r[idx*`IPL_FIELD_W +: `IPL_FIELD_W];
    endfunction : fieldOf

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [15:0] timerI2c_r;
    logic [15:0] timerI2c_nxt;
    logic [15:0] pitCmp_r;
    logic [15:0] pitCmp_nxt;
    logic [15:0] pwmAdc_r;
    logic [15:0] pwmAdc_nxt;
    logic [15:0] rdData_nxt;

    always_comb begin
        timerI2c_nxt = timerI2c_r;
        pitCmp_nxt   = pitCmp_r;
        pwmAdc_nxt   = pwmAdc_r;
        if (busReq.wr) begin
            // reserved bits are masked so they always read zero
            if (busReq.addr == `IPL_OFS_TIMER_I2C) begin
                timerI2c_nxt = busReq.wdata & `IPL_MASK_TIMER_I2C;
            end else if (busReq.addr == `IPL_OFS_PIT_CMP) begin
                pitCmp_nxt = busReq.wdata & `IPL_MASK_PIT_CMP;
            end else if (busReq.addr == `IPL_OFS_PWM_ADC) begin
                pwmAdc_nxt = busReq.wdata & `IPL_MASK_PWM_ADC;
            end
        end
    end

    always_comb begin
        rdData_nxt = 16'h0000;
        if (busReq.rd) begin
            // unmapped offsets read as zero
            if (busReq.addr == `IPL_OFS_TIMER_I2C) begin
                rdData_nxt = timerI2c_r;
            end else if (busReq.addr == `IPL_OFS_PIT_CMP) begin
                rdData_nxt = pitCmp_r;
            end else if (busReq.addr == `IPL_OFS_PWM_ADC) begin
                rdData_nxt = pwmAdc_r;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timerI2c_r <= `IPL_RESET_VAL;
            pitCmp_r   <= `IPL_RESET_VAL;
            pwmAdc_r   <= `IPL_RESET_VAL;
            rdData     <= 16'h0000;
        end else begin
            timerI2c_r <= timerI2c_nxt;
            pitCmp_r   <= pitCmp_nxt;
            pwmAdc_r   <= pwmAdc_nxt;
            rdData     <= rdData_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded outputs, combinational from the registers so they follow a write
    // on the next cycle

    assign timerCh3Level       = decodeField(fieldOf(timerI2c_r, 7));
    assign timerCh2Level       = decodeField(fieldOf(timerI2c_r, 6));
    assign timerCh1Level       = decodeField(fieldOf(timerI2c_r, 5));
    assign timerCh0Level       = decodeField(fieldOf(timerI2c_r, 4));
    assign i2cStatusLevel      = decodeField(fieldOf(timerI2c_r, 3));
    assign i2cTransmitLevel    = decodeField(fieldOf(timerI2c_r, 2));
    assign i2cReceiveLevel     = decodeField(fieldOf(timerI2c_r, 1));
    assign i2cGeneralCallLevel = decodeField(fieldOf(timerI2c_r, 0));
    assign intervalTimer1Level = decodeField(fieldOf(pitCmp_r, 7));
    assign intervalTimer0Level = decodeField(fieldOf(pitCmp_r, 6));
    assign comparatorBLevel    = decodeField(fieldOf(pitCmp_r, 5));
    assign comparatorALevel    = decodeField(fieldOf(pitCmp_r, 4));
    assign pwmFaultLevel       = decodeField(fieldOf(pwmAdc_r, 5));
    assign pwmReloadLevel      = decodeField(fieldOf(pwmAdc_r, 4));
    assign adcZeroCrossLevel   = decodeField(fieldOf(pwmAdc_r, 3));
    assign adcBDoneLevel       = decodeField(fieldOf(pwmAdc_r, 2));
    assign adcADoneLevel       = decodeField(fieldOf(pwmAdc_r, 1));
    assign intervalTimer2Level = decodeField(fieldOf(pwmAdc_r, 0));

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_disable_code;
        @(posedge clk) disable iff (rst)
        (timerI2c_r[15:14] == 2'h0) |-> !timerCh3Level.enable;
    endproperty
    a_disable_code: assert property (p_disable_code)
        else $error("zero code did not disable timer channel 3");

    property p_level_cap;
        @(posedge clk) disable iff (rst)
        pwmFaultLevel.enable |-> (pwmFaultLevel.level == pwmAdc_r[11:10] - 2'h1);
    endproperty
    a_level_cap: assert property (p_level_cap)
        else $error("pwm fault level not code minus one");

    property p_reset_clear;
        @(posedge clk) $fell(rst) |-> (timerI2c_r == 16'h0000 && pitCmp_r == 16'h0000
            && pwmAdc_r == 16'h0000);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("level registers not clear after reset");

    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        (pitCmp_r[7:0] == 8'h00) && (pwmAdc_r[15:12] == 4'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits hold a one");

    property p_write_follow;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_TIMER_I2C) |=>
            (timerCh3Level.enable == ($past(busReq.wdata[15:14]) != 2'h0));
    endproperty
    a_write_follow: assert property (p_write_follow)
        else $error("timer channel 3 did not follow write");

    property p_pit1_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_PIT_CMP && busReq.wdata[15:14] == 2'h3) |=>
            (intervalTimer1Level.enable && intervalTimer1Level.level == 2'h2);
    endproperty
    a_pit1_map: assert property (p_pit1_map)
        else $error("interval timer 1 not at level two");

    property p_pit2_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_PWM_ADC && busReq.wdata[1:0] == 2'h1) |=>
            (intervalTimer2Level.enable && intervalTimer2Level.level == 2'h0);
    endproperty
    a_pit2_map: assert property (p_pit2_map)
        else $error("interval timer 2 not at level zero");

    property p_read_back;
        @(posedge clk) disable iff (rst)
        (busReq.rd && busReq.addr == `IPL_OFS_PWM_ADC) |=> (rdData == $past(pwmAdc_r));
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read data does not match register");

    property p_i2c_gen_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_TIMER_I2C && busReq.wdata[1:0] == 2'h2) |=>
            (i2cGeneralCallLevel.enable && i2cGeneralCallLevel.level == 2'h1);
    endproperty
    a_i2c_gen_map: assert property (p_i2c_gen_map)
        else $error("i2c general call not at level one");

    property p_tmr3_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_TIMER_I2C && busReq.wdata[15:14] == 2'h3) |=>
            (timerCh3Level.enable && timerCh3Level.level == 2'h2);
    endproperty
    a_tmr3_map: assert property (p_tmr3_map)
        else $error("timer channel 3 not at level two");

    property p_tmr2_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_TIMER_I2C && busReq.wdata[13:12] == 2'h2) |=>
            (timerCh2Level.enable && timerCh2Level.level == 2'h1);
    endproperty
    a_tmr2_map: assert property (p_tmr2_map)
        else $error("timer channel 2 not at level one");

    property p_tmr1_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_TIMER_I2C && busReq.wdata[11:10] == 2'h1) |=>
            (timerCh1Level.enable && timerCh1Level.level == 2'h0);
    endproperty
    a_tmr1_map: assert property (p_tmr1_map)
        else $error("timer channel 1 not at level zero");

    property p_tmr0_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_TIMER_I2C && busReq.wdata[9:8] == 2'h3) |=>
            (timerCh0Level.enable && timerCh0Level.level == 2'h2);
    endproperty
    a_tmr0_map: assert property (p_tmr0_map)
        else $error("timer channel 0 not at level two");

    property p_i2c_stat_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_TIMER_I2C && busReq.wdata[7:6] == 2'h2) |=>
            (i2cStatusLevel.enable && i2cStatusLevel.level == 2'h1);
    endproperty
    a_i2c_stat_map: assert property (p_i2c_stat_map)
        else $error("i2c status not at level one");

    property p_i2c_tx_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_TIMER_I2C && busReq.wdata[5:4] == 2'h1) |=>
            (i2cTransmitLevel.enable && i2cTransmitLevel.level == 2'h0);
    endproperty
    a_i2c_tx_map: assert property (p_i2c_tx_map)
        else $error("i2c transmit not at level zero");

    property p_i2c_rx_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_TIMER_I2C && busReq.wdata[3:2] == 2'h3) |=>
            (i2cReceiveLevel.enable && i2cReceiveLevel.level == 2'h2);
    endproperty
    a_i2c_rx_map: assert property (p_i2c_rx_map)
        else $error("i2c receive not at level two");

    property p_pit0_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_PIT_CMP && busReq.wdata[13:12] == 2'h2) |=>
            (intervalTimer0Level.enable && intervalTimer0Level.level == 2'h1);
    endproperty
    a_pit0_map: assert property (p_pit0_map)
        else $error("interval timer 0 not at level one");

    property p_cmp_b_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_PIT_CMP && busReq.wdata[11:10] == 2'h1) |=>
            (comparatorBLevel.enable && comparatorBLevel.level == 2'h0);
    endproperty
    a_cmp_b_map: assert property (p_cmp_b_map)
        else $error("comparator b not at level zero");

    property p_cmp_a_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_PIT_CMP && busReq.wdata[9:8] == 2'h3) |=>
            (comparatorALevel.enable && comparatorALevel.level == 2'h2);
    endproperty
    a_cmp_a_map: assert property (p_cmp_a_map)
        else $error("comparator a not at level two");

    property p_pwm_fault_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_PWM_ADC && busReq.wdata[11:10] == 2'h2) |=>
            (pwmFaultLevel.enable && pwmFaultLevel.level == 2'h1);
    endproperty
    a_pwm_fault_map: assert property (p_pwm_fault_map)
        else $error("pwm fault not at level one");

    property p_pwm_reload_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_PWM_ADC && busReq.wdata[9:8] == 2'h1) |=>
            (pwmReloadLevel.enable && pwmReloadLevel.level == 2'h0);
    endproperty
    a_pwm_reload_map: assert property (p_pwm_reload_map)
        else $error("pwm reload not at level zero");

    property p_adc_zc_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_PWM_ADC && busReq.wdata[7:6] == 2'h3) |=>
            (adcZeroCrossLevel.enable && adcZeroCrossLevel.level == 2'h2);
    endproperty
    a_adc_zc_map: assert property (p_adc_zc_map)
        else $error("adc zero crossing not at level two");

    property p_adc_b_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_PWM_ADC && busReq.wdata[5:4] == 2'h2) |=>
            (adcBDoneLevel.enable && adcBDoneLevel.level == 2'h1);
    endproperty
    a_adc_b_map: assert property (p_adc_b_map)
        else $error("adc b conversion complete not at level one");

    property p_adc_a_map;
        @(posedge clk) disable iff (rst)
        (busReq.wr && busReq.addr == `IPL_OFS_PWM_ADC && busReq.wdata[3:2] == 2'h1) |=>
            (adcADoneLevel.enable && adcADoneLevel.level == 2'h0);
    endproperty
    a_adc_a_map: assert property (p_adc_a_map)
        else $error("adc a conversion complete not at level zero");

    // level three has no encoding, so any source showing it means a broken decode
    property p_no_level_three;
        @(posedge clk) disable iff (rst)
        (timerCh3Level.level != 2'h3) && (timerCh2Level.level != 2'h3)
            && (timerCh1Level.level != 2'h3) && (timerCh0Level.level != 2'h3)
            && (i2cStatusLevel.level != 2'h3) && (i2cTransmitLevel.level != 2'h3)
            && (i2cReceiveLevel.level != 2'h3) && (i2cGeneralCallLevel.level != 2'h3)
            && (intervalTimer1Level.level != 2'h3) && (intervalTimer0Level.level != 2'h3)
            && (comparatorBLevel.level != 2'h3) && (comparatorALevel.level != 2'h3)
            && (pwmFaultLevel.level != 2'h3) && (pwmReloadLevel.level != 2'h3)
            && (adcZeroCrossLevel.level != 2'h3) && (adcBDoneLevel.level != 2'h3)
            && (adcADoneLevel.level != 2'h3) && (intervalTimer2Level.level != 2'h3);
    endproperty
    a_no_level_three: assert property (p_no_level_three)
        else $error("a source shows a level above two");

    property p_hold_no_write;
        @(posedge clk) disable iff (rst)
        !busReq.wr |=> ($stable(timerI2c_r) && $stable(pitCmp_r) && $stable(pwmAdc_r));
    endproperty
    a_hold_no_write: assert property (p_hold_no_write)
        else $error("level register changed without a write");

    property p_disabled_level_zero;
        @(posedge clk) disable iff (rst)
        !comparatorBLevel.enable |-> (comparatorBLevel.level == 2'h0
            && pitCmp_r[11:10] == 2'h0);
    endproperty
    a_disabled_level_zero: assert property (p_disabled_level_zero)
        else $error("disabled comparator b shows a level or a nonzero code");

    property p_reserved_read_pit;
        @(posedge clk) disable iff (rst)
        (busReq.rd && busReq.addr == `IPL_OFS_PIT_CMP) |=> (rdData[7:0] == 8'h00);
    endproperty
    a_reserved_read_pit: assert property (p_reserved_read_pit)
        else $error("reserved low byte of interval timer register read as one");

    property p_reserved_read_pwm;
        @(posedge clk) disable iff (rst)
        (busReq.rd && busReq.addr == `IPL_OFS_PWM_ADC) |=> (rdData[15:12] == 4'h0);
    endproperty
    a_reserved_read_pwm: assert property (p_reserved_read_pwm)
        else $error("reserved top bits of pwm adc register read as one");

endmodule : ipl_level_regs

// *** sim/ipl_core_model.sv ***
// core-side register master model for the level registers
module ipl_core_model
    import ipl_pkg::*;
(
    // clock
    input  wire logic             clk,
    // register port
    output ipl_pkg::ipl_bus_req_t busReq,
    input  wire logic [15:0]      rdData
);
    timeunit 1ns;
    timeprecision 1ps;

    initial busReq = '0;

    ////////////////////////////////////////////////////////////////////////////
    // software never sets reserved bits, so data is masked before it goes out
    task automatic write_reg(input logic [3:0] a, input logic [15:0] d, input logic [15:0] m);
        @(posedge clk);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d & m};
        @(posedge clk);
        busReq <= '0;
        #1;
    endtask : write_reg

    // read data is only valid in the single cycle after the strobe
    task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        busReq <= '0;
        #1 d = rdData;
    endtask : read_reg
endmodule : ipl_core_model

// *** sim/testbench.sv ***
// self-checking bench for the priority level registers
`include "ipl_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ipl_pkg::*;

    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    ipl_bus_req_t           busReq;
    logic [15:0]            rdData;
    wire ipl_src_t          src [24];
    logic [15:0]            rd;
    int                     n_fail = 0;
    int                     checks = 0;
    localparam logic [3:0]  OFS [3] = '{`IPL_OFS_TIMER_I2C, `IPL_OFS_PIT_CMP, `IPL_OFS_PWM_ADC};
    localparam logic [15:0] MSK [3] = '{`IPL_MASK_TIMER_I2C, `IPL_MASK_PIT_CMP,
                                        `IPL_MASK_PWM_ADC};

    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // slot index is register number times eight plus field number
    assign src[8] = '0;
    assign src[9] = '0;
    assign src[10] = '0;
    assign src[11] = '0;
    assign src[22] = '0;
    assign src[23] = '0;

    ipl_core_model u_ipl_core_model (.clk(clk), .busReq(busReq), .rdData(rdData));

    ipl_level_regs u_ipl_level_regs (
        .clk                 (clk),
        .rst                 (rst),
        .busReq              (busReq),
        .rdData              (rdData),
        .timerCh3Level       (src[7]),
        .timerCh2Level       (src[6]),
        .timerCh1Level       (src[5]),
        .timerCh0Level       (src[4]),
        .i2cStatusLevel      (src[3]),
        .i2cTransmitLevel    (src[2]),
        .i2cReceiveLevel     (src[1]),
        .i2cGeneralCallLevel (src[0]),
        .intervalTimer1Level (src[15]),
        .intervalTimer0Level (src[14]),
        .comparatorBLevel    (src[13]),
        .comparatorALevel    (src[12]),
        .pwmFaultLevel       (src[21]),
        .pwmReloadLevel      (src[20]),
        .adcZeroCrossLevel   (src[19]),
        .adcBDoneLevel       (src[18]),
        .adcADoneLevel       (src[17]),
        .intervalTimer2Level (src[16])
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // decoded view first, then readback of all three registers
    task automatic check_all(input logic [15:0] v [3]);
        logic [1:0]  c;
        logic [15:0] e;
        for (int i = 0; i < 24; i++) begin
            c = 2'((v[i/8] & MSK[i/8]) >> (2 * (i % 8)));
            e = {13'h0000, c != 2'b00, (c == 2'b00) ? 2'b00 : c - 2'b01};
            check("decoded source", 16'(src[i]), e);
        end
        for (int r = 0; r < 3; r++) begin
            u_ipl_core_model.read_reg(OFS[r], rd);
            check("register readback", rd, v[r] & MSK[r]);
        end
    endtask : check_all

    task automatic write_all(input logic [15:0] v [3]);
        for (int r = 0; r < 3; r++) begin
            u_ipl_core_model.write_reg(OFS[r], v[r], MSK[r]);
        end
    endtask : write_all

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] v [3];
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        v = '{3{16'h0000}};
        check_all(v);
        $display("test reset values done");
        for (int c = 0; c < 4; c++) begin
            v = '{3{16'(c * 16'h5555)}};
            write_all(v);
            check_all(v);
        end
        $display("test every code in every field done");
        // a single nonzero field per write catches swapped or shifted fields
        for (int i = 0; i < 24; i++) begin
            v = '{3{16'h0000}};
            v[i/8] = 16'(((i % 3) + 1) << (2 * (i % 8)));
            write_all(v);
            check_all(v);
        end
        $display("test single field mapping done");
        u_ipl_core_model.write_reg(4'h7, 16'hFFFF, 16'hFFFF);
        u_ipl_core_model.write_reg(4'h3, 16'hFFFF, 16'hFFFF);
        check_all(v);
        u_ipl_core_model.read_reg(4'h7, rd);
        check("unmapped readback", rd, 16'h0000);
        $display("test unmapped offsets done");
        // second reset in mid-run with every field set
        v = '{3{16'hFFFF}};
        write_all(v);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        v = '{3{16'h0000}};
        check_all(v);
        $display("test reset in mid-run done");
        close_out();
    end
endmodule : testbench
